// ==== pkg/host_port_params.svh ====
// Purpose: constants for the host parallel bus port
// Assumes: 50 MHz system clock
// Notes: strap codes and timing counts live here
//
// What this block does
// R1 - Direct mode: address bits 15..1 plus bit 0 select the accessed location; the code decodes only bits 1 and 0.
// R2 - Indirect mode: host holds address bits 15..1 at ground.
// R3 - Indirect: bit 0 with strobes gives transfer kind; direct: address bit 0.
// R4 - Eight-bit tristate data bus, released while reset is applied.
// R5 - Static address-mode strap picks direct or indirect addressing.
// R6 - Two bus-type straps pick generic, strobe-acknowledge or enable-clock bus.
// R7 - Generic bus: drive data only while read strobe low and selected.
// R8 - Enable-clock bus: read pin is enable; transfer when it rises high.
// R9 - Strobe bus: read pin is lower lane strobe; transfer when it falls.
// R10 - Generic bus: write data captured on write strobe rising edge.
// R11 - Enable-clock bus: write pin high means read, low means write.
// R12 - Active-low chip select gates every host transfer.
// R13 - Generic bus: wait low during transfer, high on completion, then released.
// R14 - Indirect mode: host may use wait output as completion handshake.
// R15 - Strobe bus: acknowledge high inserts waits, inactive on completion, released.
// R16 - Enable-clock bus: host leaves the wait pin floating.
// R17 - Strobe bus: address strobe qualifies access; otherwise host ties it high.
// R18 - Hardware reset restores defaults and makes all outputs inactive.
// R19 - Chip select high: strobes ignored, data and wait released; the code keeps driving wait until a transfer already started completes.
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// ----------------------------------------
// Strap encodings
// ----------------------------------------
`define BUS_GENERIC 2'h0
`define BUS_ADDR_STROBE 2'h1
`define BUS_ENABLE_CLK 2'h2
`define ADDR_DIRECT 1'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define ACCESS_TIME_NS 60
`define ACCESS_CYCLES ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACK_HOLD_CYCLES 1

`endif

// ==== pkg/host_port_pkg.sv ====
// Purpose: types for the host parallel bus port
// Assumes: nothing
// Notes: state codes are one-hot
package host_port_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_BUSY = 4'h2,
		ST_DONE = 4'h4,
		ST_WAIT_END = 4'h8
	} port_state_t;
endpackage : host_port_pkg

// ==== pkg/access_if.sv ====
// Purpose: carries decoded accesses between front end and access engine
// Assumes: single clock
// Notes: start is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface access_if;
	logic start;
	logic is_write;
	logic [7:0] wdata;
	logic [15:0] addr;
	logic busy;
	modport front (output start, output is_write, output wdata, output addr, input busy);
	modport engine (input start, input is_write, input wdata, input addr, output busy);
endinterface : access_if
`default_nettype wire

// ==== core/access_engine.sv ====
// Purpose: timed execution of one decoded host access
// Assumes: start only while idle
// Notes: holds busy for the fixed access time
`timescale 1ns/1ps
`include "host_port_params.svh"
`default_nettype none
module access_engine (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// Decoded access
	access_if.engine acc
);
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;

	// Count down the access time
	always_comb begin
		cnt_next = cnt_reg;
		if (acc.start) begin
			cnt_next = 4'(`ACCESS_CYCLES);
		end else if (cnt_reg != 4'h0) begin
			cnt_next = cnt_reg - 4'h1;
		end
	end

	// Register the counter
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_reg <= 4'h0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign acc.busy = (cnt_reg != 4'h0);

	a_busy_len: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R14]
		acc.start |=> acc.busy [*3] ##1 !acc.busy)
		else $error("access time wrong");
endmodule : access_engine
`default_nettype wire

// ==== core/host_bus_port.sv ====
// Purpose: host parallel bus port with three strap-selected bus styles
// Assumes: host pins synchronous to sys_clk_i; straps static
// Notes: memory behind the port is a small register bank
`timescale 1ns/1ps
`include "host_port_params.svh"
`default_nettype none
module host_bus_port (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// Straps
	input wire logic addr_mode_strap_i,
	input wire logic bus_type_strap_hi_i,
	input wire logic bus_type_strap_lo_i,
	// Host control
	input wire logic chip_sel_n_i,
	input wire logic rd_strobe_i,
	input wire logic wr_strobe_i,
	input wire logic addr_strobe_n_i,
	input wire logic [15:1] addr_hi_i,
	input wire logic cmd_data_select_i,
	// Data bus
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_n_o,
	// Wait / acknowledge
	output logic transfer_ack_out_o,
	output logic transfer_ack_oe_n_o,
	// Captured command byte
	output logic [7:0] last_cmd_o
);
	access_if acc ();

	// ----------------------------------------
	// Straps caught after reset
	// ----------------------------------------
	logic straps_ok_reg;
	logic direct_reg;
	logic [1:0] bus_reg;
	logic straps_ok_next;
	logic direct_next;
	logic [1:0] bus_next;

	// Straps are static; sample once after release so reset holds constants
	always_comb begin
		straps_ok_next = 1'b1;
		direct_next = direct_reg;
		bus_next = bus_reg;
		if (!straps_ok_reg) begin
			direct_next = addr_mode_strap_i; // [R5]
			bus_next = {bus_type_strap_hi_i, bus_type_strap_lo_i}; // [R6]
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			straps_ok_reg <= 1'b0;
			direct_reg <= 1'b0;
			bus_reg <= 2'h0;
		end else begin
			straps_ok_reg <= straps_ok_next;
			direct_reg <= direct_next;
			bus_reg <= bus_next;
		end
	end

	// ----------------------------------------
	// Strobe decode per bus style
	// ----------------------------------------
	logic sel;
	logic active;
	logic want_write;
	logic wr_prev_reg;
	logic as_ok;

	// Active level of the access window for the chosen style
	always_comb begin
		sel = !chip_sel_n_i && straps_ok_reg; // [R12] [R19]
		as_ok = (bus_reg != `BUS_ADDR_STROBE) || !addr_strobe_n_i; // [R17]
		unique case (bus_reg)
			`BUS_ADDR_STROBE: begin
				active = !rd_strobe_i; // [R9]
				want_write = !wr_strobe_i;
			end
			`BUS_ENABLE_CLK: begin
				active = rd_strobe_i; // [R8]
				want_write = !wr_strobe_i; // [R11]
			end
			default: begin
				active = !rd_strobe_i || !wr_strobe_i;
				want_write = !wr_strobe_i;
			end
		endcase
	end

	// ----------------------------------------
	// Transfer state machine
	// ----------------------------------------
	host_port_pkg::port_state_t st_reg;
	host_port_pkg::port_state_t st_next;
	logic [7:0] bank_reg [0:3];
	logic [7:0] bank_next [0:3];
	logic [1:0] idx_reg;
	logic [1:0] idx_next;
	logic wr_pend_reg;
	logic wr_pend_next;
	logic [7:0] dout_reg;
	logic [7:0] dout_next;
	logic doe_n_reg;
	logic doe_n_next;
	logic ack_reg;
	logic ack_next;
	logic aoe_n_reg;
	logic aoe_n_next;
	logic [7:0] cmd_reg;
	logic [7:0] cmd_next;
	logic start_c;

	// Location index: direct uses address bits 1 and 0, indirect uses bit 0 only
	function automatic logic [1:0] loc_index(input logic dir, input logic [15:1] hi,
		input logic a0);
		loc_index = dir ? {hi[1], a0} : {1'b0, a0}; // [R1] [R2] [R3]
	endfunction : loc_index

	// Sequencing of a transfer and its handshake pin
	always_comb begin
		st_next = st_reg;
		bank_next = bank_reg;
		idx_next = idx_reg;
		wr_pend_next = wr_pend_reg;
		dout_next = dout_reg;
		doe_n_next = 1'b1;
		ack_next = ack_reg;
		aoe_n_next = aoe_n_reg;
		cmd_next = cmd_reg;
		start_c = 1'b0;
		unique case (st_reg)
			host_port_pkg::ST_IDLE: begin
				aoe_n_next = 1'b1;
				if (sel && active && as_ok) begin
					st_next = host_port_pkg::ST_BUSY;
					start_c = 1'b1;
					idx_next = loc_index(direct_reg, addr_hi_i, cmd_data_select_i);
					wr_pend_next = want_write;
					// Wait asserted: low on generic, high on strobe bus [R13] [R15]
					ack_next = (bus_reg == `BUS_ADDR_STROBE);
					aoe_n_next = (bus_reg == `BUS_ENABLE_CLK); // [R16]
				end
			end
			host_port_pkg::ST_BUSY: begin
				if (!acc.busy) begin
					st_next = host_port_pkg::ST_DONE;
					ack_next = (bus_reg != `BUS_ADDR_STROBE); // Completion level [R14]
				end
			end
			host_port_pkg::ST_DONE: begin
				st_next = host_port_pkg::ST_WAIT_END;
				aoe_n_next = 1'b1; // Release after one cycle inactive [R13] [R15]
			end
			default: begin
				aoe_n_next = 1'b1;
				if (!sel || !active) begin
					st_next = host_port_pkg::ST_IDLE;
				end
			end
		endcase
		// Generic write data taken on the rising write strobe [R10]
		if (sel && bus_reg == `BUS_GENERIC && !wr_prev_reg && wr_strobe_i && wr_pend_reg) begin
			bank_next[idx_reg] = data_i;
			if (idx_reg == 2'h1) begin
				cmd_next = data_i;
			end
		end
		// Other styles capture in the done state, whether or not the strobe is still active
		if (sel && bus_reg != `BUS_GENERIC && st_reg == host_port_pkg::ST_DONE && wr_pend_reg) begin
			bank_next[idx_reg] = data_i;
			if (idx_reg == 2'h1) begin
				cmd_next = data_i;
			end
		end
		// Drive read data only within the read window [R7] [R19]
		if (sel && active && !want_write && st_reg != host_port_pkg::ST_IDLE) begin
			doe_n_next = 1'b0;
			dout_next = bank_reg[idx_reg];
		end
	end

	// Register all transfer state; reset releases pins [R4] [R18]
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_reg <= host_port_pkg::ST_IDLE;
			for (int i = 0; i < 4; i++) begin
				bank_reg[i] <= 8'h00;
			end
			idx_reg <= 2'h0;
			wr_pend_reg <= 1'b0;
			dout_reg <= 8'h00;
			doe_n_reg <= 1'b1;
			ack_reg <= 1'b1;
			aoe_n_reg <= 1'b1;
			cmd_reg <= 8'h00;
			wr_prev_reg <= 1'b1;
		end else begin
			st_reg <= st_next;
			bank_reg <= bank_next;
			idx_reg <= idx_next;
			wr_pend_reg <= wr_pend_next;
			dout_reg <= dout_next;
			doe_n_reg <= doe_n_next;
			ack_reg <= ack_next;
			aoe_n_reg <= aoe_n_next;
			cmd_reg <= cmd_next;
			wr_prev_reg <= wr_strobe_i;
		end
	end

	assign acc.start = start_c;
	assign acc.is_write = want_write;
	assign acc.wdata = data_i;
	assign acc.addr = {addr_hi_i, cmd_data_select_i};

	access_engine u_engine (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.acc(acc)
	);

	assign data_o = dout_reg;
	assign data_oe_n_o = doe_n_reg;
	assign transfer_ack_out_o = ack_reg;
	assign transfer_ack_oe_n_o = aoe_n_reg;
	assign last_cmd_o = cmd_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_done_then_release;
		(st_reg == host_port_pkg::ST_DONE) ##1 aoe_n_reg;
	endsequence

	a_desel_quiet: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R19]
		chip_sel_n_i |=> data_oe_n_o)
		else $error("data driven while deselected");
	a_generic_rd: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R7]
		(bus_reg == `BUS_GENERIC && rd_strobe_i && !wr_strobe_i) |=> data_oe_n_o)
		else $error("data driven without read strobe");
	a_wait_low: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R13]
		(bus_reg == `BUS_GENERIC && st_reg == host_port_pkg::ST_IDLE && st_next == host_port_pkg::ST_BUSY)
		|=> !transfer_ack_out_o && !transfer_ack_oe_n_o)
		else $error("wait not asserted");
	a_ack_high: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R15]
		(bus_reg == `BUS_ADDR_STROBE && st_reg == host_port_pkg::ST_IDLE && st_next == host_port_pkg::ST_BUSY)
		|=> transfer_ack_out_o)
		else $error("acknowledge not high");
	a_release_after: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R13]
		(st_reg == host_port_pkg::ST_BUSY && st_next == host_port_pkg::ST_DONE) |=> s_done_then_release)
		else $error("wait not released");
	a_enclk_float: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R16]
		(bus_reg == `BUS_ENABLE_CLK) |=> transfer_ack_oe_n_o)
		else $error("wait driven on enable bus");
	a_busy_bound: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R14]
		(st_reg == host_port_pkg::ST_BUSY) |-> ##[1:6] (st_reg == host_port_pkg::ST_DONE))
		else $error("transfer never completes");
	a_as_gate: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R17]
		(bus_reg == `BUS_ADDR_STROBE && addr_strobe_n_i && st_reg == host_port_pkg::ST_IDLE)
		|=> st_reg == host_port_pkg::ST_IDLE)
		else $error("access without address strobe");

	// Step shapes of the wait pin; completion is held one cycle before release
	sequence s_wait_complete;
		transfer_ack_out_o && !transfer_ack_oe_n_o;
	endsequence

	sequence s_ack_complete;
		!transfer_ack_out_o && !transfer_ack_oe_n_o;
	endsequence

	sequence s_pin_released;
		transfer_ack_oe_n_o;
	endsequence

	// Rising write strobe on the command location while selected
	sequence s_cmd_wr_rise;
		straps_ok_reg && !chip_sel_n_i && bus_reg == `BUS_GENERIC && wr_pend_reg
		&& idx_reg == 2'h1 && !wr_prev_reg && wr_strobe_i;
	endsequence

	a_wait_done: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R13]
		(bus_reg == `BUS_GENERIC && st_reg == host_port_pkg::ST_BUSY
		&& st_next == host_port_pkg::ST_DONE) |=> s_wait_complete ##1 s_pin_released)
		else $error("wait completion level wrong");
	a_ack_done: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R15]
		(bus_reg == `BUS_ADDR_STROBE && st_reg == host_port_pkg::ST_BUSY
		&& st_next == host_port_pkg::ST_DONE) |=> s_ack_complete ##1 s_pin_released)
		else $error("acknowledge completion level wrong");
	a_desel_wait: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R19]
		(chip_sel_n_i && st_reg == host_port_pkg::ST_IDLE) |=> transfer_ack_oe_n_o)
		else $error("wait driven while deselected");
	a_cmd_capture: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R10]
		s_cmd_wr_rise |=> last_cmd_o == $past(data_i))
		else $error("write data not taken on strobe rise");
	a_lane_start: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R9]
		(bus_reg == `BUS_ADDR_STROBE && straps_ok_reg && st_reg == host_port_pkg::ST_IDLE
		&& !chip_sel_n_i && !rd_strobe_i && !addr_strobe_n_i)
		|=> st_reg == host_port_pkg::ST_BUSY)
		else $error("lane strobe did not start a transfer");
	a_enable_start: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R8]
		(bus_reg == `BUS_ENABLE_CLK && straps_ok_reg && st_reg == host_port_pkg::ST_IDLE
		&& !chip_sel_n_i && rd_strobe_i) |=> st_reg == host_port_pkg::ST_BUSY)
		else $error("enable clock did not start a transfer");
endmodule : host_bus_port
`default_nettype wire

// ==== bench/host_cpu_model.sv ====
// Purpose: host processor model for the parallel host port
// Assumes: straps fixed between resets; pins change 1 ns after a rising edge
// Notes: an undriven data wire shows the inverse of its last value
`timescale 1ns/1ps
`include "host_port_params.svh"
`default_nettype none
module host_cpu_model (
	// Clock and bus style
	input wire logic sys_clk_i,
	input wire logic [1:0] style_i,
	// Host control pins
	output logic cs_n_o,
	output logic rd_o,
	output logic wr_o,
	output logic as_n_o,
	output logic [15:0] addr_o,
	// Data wire and device outputs
	output logic [7:0] bus_o,
	input wire logic [7:0] dev_data_i,
	input wire logic dev_oe_n_i,
	input wire logic ack_i,
	input wire logic ack_oe_n_i
);
	logic drive;
	logic [7:0] wdat;
	logic [7:0] last;
	// Resolved data wire; no stale copy when nobody drives
	assign bus_o = !dev_oe_n_i ? dev_data_i : (drive ? wdat : ~last);
	always @(posedge sys_clk_i) last <= bus_o;
	// Idle levels for the selected style
	task park;
		cs_n_o = 1'b1;
		rd_o = (style_i != `BUS_ENABLE_CLK);
		wr_o = 1'b1;
		as_n_o = 1'b1;
		addr_o = 16'h0000;
		drive = 1'b0;
	endtask : park
	// One transfer held until completion, or for a fixed window on the enable bus; waited flags the handshake
	task access(input logic wr_en, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic waited);
		logic act;
		logic seen;
		act = (style_i == `BUS_ADDR_STROBE);
		seen = 1'b0;
		waited = 1'b0;
		q = 8'h00;
		@(posedge sys_clk_i);
		#1;
		cs_n_o = 1'b0;
		addr_o = a;
		drive = wr_en;
		wdat = d;
		if (style_i == `BUS_GENERIC) begin
			rd_o = wr_en;
			wr_o = !wr_en;
		end else begin
			wr_o = !wr_en;
			rd_o = (style_i == `BUS_ENABLE_CLK);
			as_n_o = !act;
		end
		for (int n = 0; n < 16; n++) begin
			@(posedge sys_clk_i);
			#1;
			q = bus_o;
			if (style_i == `BUS_ENABLE_CLK) begin
				// No wait pin here, so hold a fixed window
				if (!ack_oe_n_i) waited = 1'b1;
				if (n == 7) break;
			end else begin
				if (!ack_oe_n_i && ack_i === act) seen = 1'b1;
				if (seen && !ack_oe_n_i && ack_i === !act) begin
					waited = 1'b1;
					break;
				end
			end
		end
		// Strobes drop first so the write edge still sees chip select low
		wr_o = 1'b1;
		rd_o = (style_i != `BUS_ENABLE_CLK);
		as_n_o = 1'b1;
		@(posedge sys_clk_i);
		#1;
		park();
	endtask : access
	// Strobe activity while deselected; drove reports any output enable
	task stray(output logic drove);
		drove = 1'b0;
		@(posedge sys_clk_i);
		#1;
		rd_o = 1'b0;
		wr_o = 1'b0;
		repeat (8) begin
			@(posedge sys_clk_i);
			#1;
			drove = drove | !dev_oe_n_i | !ack_oe_n_i;
		end
		park();
	endtask : stray
endmodule : host_cpu_model
`default_nettype wire

// ==== bench/tb_lcd_ctrl_host_bus_port.sv ====
// Purpose: self-checking bench for the host parallel bus port
// Assumes: bank of four bytes behind the port
// Notes: each bus style is entered through its own reset
`timescale 1ns/1ps
`include "host_port_params.svh"
`default_nettype none
module tb_lcd_ctrl_host_bus_port;
	logic sys_clk_i;
	logic reset_n_i;
	logic mode;
	logic [1:0] style;
	logic cs_n, rd, wr, as_n;
	logic [15:0] haddr;
	logic [7:0] bus, dout, last_cmd;
	logic doe_n, ack, ack_oe_n;
	int bad_count;
	int check_count;
	int cyc;
	// ----------------------------------------
	// Clock, instances, timeout
	// ----------------------------------------
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	host_bus_port uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.addr_mode_strap_i(mode), .bus_type_strap_hi_i(style[1]),
		.bus_type_strap_lo_i(style[0]), .chip_sel_n_i(cs_n), .rd_strobe_i(rd),
		.wr_strobe_i(wr), .addr_strobe_n_i(as_n), .addr_hi_i(haddr[15:1]),
		.cmd_data_select_i(haddr[0]), .data_i(bus), .data_o(dout),
		.data_oe_n_o(doe_n), .transfer_ack_out_o(ack),
		.transfer_ack_oe_n_o(ack_oe_n), .last_cmd_o(last_cmd));
	host_cpu_model host (.sys_clk_i(sys_clk_i), .style_i(style), .cs_n_o(cs_n),
		.rd_o(rd), .wr_o(wr), .as_n_o(as_n), .addr_o(haddr), .bus_o(bus),
		.dev_data_i(dout), .dev_oe_n_i(doe_n), .ack_i(ack), .ack_oe_n_i(ack_oe_n));
	// Ceiling well above the few hundred cycles the run needs
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 8000) begin
			bad_count++;
			end_sim();
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task end_sim;
		$display("checks=%0d errors=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	// Straps settle before release; outputs released while held
	task do_reset(input logic m, input logic [1:0] s);
		@(posedge sys_clk_i);
		#1;
		mode = m;
		style = s;
		reset_n_i = 1'b0;
		// Let the new style reach the model before parking its pins
		#1;
		host.park();
		repeat (20) @(posedge sys_clk_i);
		#1;
		chk({5'h00, doe_n, ack_oe_n, ack}, 8'h07);
		reset_n_i = 1'b1;
		repeat (3) @(posedge sys_clk_i);
	endtask : do_reset
	// Write n locations then read back, each with its handshake
	task bank_test(input logic [15:0] base, input int n);
		logic [7:0] q;
		logic w;
		logic [7:0] exp [4];
		for (int i = 0; i < n; i++) begin
			exp[i] = 8'h3c + 8'(i * 8'h47);
			host.access(1'b1, base | 16'(i), exp[i], q, w);
			chk({7'h00, w}, {7'h00, style != `BUS_ENABLE_CLK});
		end
		for (int i = 0; i < n; i++) begin
			host.access(1'b0, base | 16'(i), 8'h00, q, w);
			chk(q, exp[i]);
		end
		chk(last_cmd, exp[1]);
	endtask : bank_test
	// Deselected strobes must leave both outputs released
	task stray_test;
		logic drove;
		host.stray(drove);
		chk({7'h00, drove}, 8'h00);
	endtask : stray_test
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		reset_n_i = 1'b0;
		mode = `ADDR_DIRECT;
		style = `BUS_GENERIC;
		bad_count = 0;
		check_count = 0;
		host.park();
		do_reset(`ADDR_DIRECT, `BUS_GENERIC);
		bank_test(16'h5a50, 4);
		stray_test();
		do_reset(`ADDR_DIRECT, `BUS_ADDR_STROBE);
		bank_test(16'h0c30, 4);
		do_reset(~`ADDR_DIRECT, `BUS_GENERIC);
		bank_test(16'h0000, 2);
		do_reset(~`ADDR_DIRECT, `BUS_ENABLE_CLK);
		bank_test(16'h0000, 2);
		end_sim();
	end
endmodule : tb_lcd_ctrl_host_bus_port
`default_nettype wire
